// *** shared/tcg_cfg.svh ***
`ifndef TCG_CFG_SVH
`define TCG_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define TCG_OFF_GATE 12'h000
`define TCG_OFF_PRESCALE 12'h004
`define TCG_OFF_DIVIDER 12'h008
`define TCG_OFF_CHAN_BASE 12'h010
`define TCG_CHANNELS 8
`define TCG_CHAN_IDX_W 3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCG_GATE_TIMER_A 0
`define TCG_GATE_W 8
`define TCG_PRESCALE_W 16
`define TCG_PRESCALE_MASK 16'h33FF
`define TCG_PICK_HI 15
`define TCG_PICK_LO 14
`define TCG_DIV_W 15

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCG_GATE_RST 8'h00
`define TCG_PRESCALE_RST 16'h0000
`define TCG_PICK_RST 2'h0
`define TCG_DIV_RST 15'h0000

`endif

// *** shared/tcg_pkg.sv ***
`default_nettype none

package tcg_pkg;

    // channel operation clock pick, in field value order
    typedef enum logic [1:0] {
        TCG_PICK_ZERO,
        TCG_PICK_TWO,
        TCG_PICK_ONE,
        TCG_PICK_THREE
    } tcg_pick_e;

    // timer prescaler select register layout
    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic [1:0] prescale_three_select;
        logic [1:0] rsvd_mid;
        logic [1:0] prescale_two_select;
        logic [3:0] prescale_one_select;
        logic [3:0] prescale_zero_select;
    } tcg_prescale_s;

    // peripheral clock gate register layout
    typedef struct packed {
        logic calendar_clock_gate;
        logic serial_bus_b_clock_gate;
        logic converter_clock_gate;
        logic serial_bus_a_clock_gate;
        logic serial_array_b_clock_gate;
        logic serial_array_a_clock_gate;
        logic timer_unit_b_clock_gate;
        logic timer_unit_a_clock_gate;
    } tcg_gate_s;

endpackage

`default_nettype wire

// *** design/tcg_top.sv ***
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "tcg_cfg.svh"
`default_nettype none

// Operation
// - timer unit a gets its clock only while gate bit 0 is one
// - eight-bit gate register, one bit per peripheral clock
// - prescaled clock zero is main clock divided by two to field
// - sixteen-bit prescaler select, four fields, unused bits read zero
// - channel mode bits 15:14 pick prescaled clock zero, two, one, three
module tcg_top
    import tcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`TCG_GATE_W-1:0] peripheral_clock_gate,
    output logic [3:0] prescaled_clock,
    output logic [`TCG_CHANNELS-1:0] channel_tick
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tcg_gate_s gate_q, gate_d;
    tcg_prescale_s ps_q, ps_d;
    tcg_pick_e pick_q [`TCG_CHANNELS];
    tcg_pick_e pick_d [`TCG_CHANNELS];
    logic [31:0] rdata_q, rdata_d;
    logic [`TCG_DIV_W-1:0] div_q, div_d;
    logic [3:0] tick_q, tick_d;
    logic [`TCG_CHANNELS-1:0] chan_q, chan_d;

    logic setup;
    logic access;
    logic hit_gate;
    logic hit_ps;
    logic hit_div;
    logic hit_chan;
    logic [11:0] chan_off;
    logic [`TCG_CHAN_IDX_W-1:0] chan_idx;
    logic unit_on;
    logic [3:0] sel_a [4];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_gate = (paddr == `TCG_OFF_GATE);
    assign hit_ps = (paddr == `TCG_OFF_PRESCALE);
    assign hit_div = (paddr == `TCG_OFF_DIVIDER);
    assign chan_off = paddr - `TCG_OFF_CHAN_BASE;
    assign hit_chan = (chan_off[11:5] == 7'h00) &&
        (chan_off[1:0] == 2'h0);
    assign chan_idx = chan_off[2 +: `TCG_CHAN_IDX_W];
    assign unit_on = gate_q.timer_unit_a_clock_gate;

    assign pready = 1'b1;
    assign pslverr = access && !(hit_gate || hit_ps || hit_div || hit_chan);
    assign prdata = rdata_q;

    // ------------------------------------------------------------
    // register writes and register flops
    // ------------------------------------------------------------
    always_comb begin
        gate_d = gate_q;
        ps_d = ps_q;
        for (int i = 0; i < `TCG_CHANNELS; i++) begin
            pick_d[i] = pick_q[i];
        end
        if (access && pwrite) begin
            if (hit_gate) begin
                gate_d = tcg_gate_s'(pwdata[`TCG_GATE_W-1:0]);
            end
            if (hit_ps && unit_on) begin
                ps_d = tcg_prescale_s'(pwdata[`TCG_PRESCALE_W-1:0] &
                    `TCG_PRESCALE_MASK);
            end
            if (hit_chan && unit_on) begin
                pick_d[chan_idx] =
                    tcg_pick_e'(pwdata[`TCG_PICK_HI:`TCG_PICK_LO]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_q <= tcg_gate_s'(`TCG_GATE_RST);
            ps_q <= tcg_prescale_s'(`TCG_PRESCALE_RST);
            for (int i = 0; i < `TCG_CHANNELS; i++) begin
                pick_q[i] <= tcg_pick_e'(`TCG_PICK_RST);
            end
        end else begin
            gate_q <= gate_d;
            ps_q <= ps_d;
            for (int i = 0; i < `TCG_CHANNELS; i++) begin
                pick_q[i] <= pick_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // read data, loaded at the setup edge
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            if (!pwrite) begin
                if (hit_gate) begin
                    rdata_d[`TCG_GATE_W-1:0] = gate_q;
                end
                if (hit_ps) begin
                    rdata_d[`TCG_PRESCALE_W-1:0] = ps_q;
                end
                if (hit_div) begin
                    rdata_d[`TCG_DIV_W-1:0] = div_q;
                end
                if (hit_chan) begin
                    rdata_d[`TCG_PICK_HI:`TCG_PICK_LO] = pick_q[chan_idx];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign peripheral_clock_gate = gate_q;

    // ------------------------------------------------------------
    // prescaler divider and enable pulses
    // ------------------------------------------------------------
    always_comb begin
        sel_a[0] = ps_q.prescale_zero_select;
        sel_a[1] = ps_q.prescale_one_select;
        sel_a[2] = {2'h0, ps_q.prescale_two_select};
        sel_a[3] = {2'h0, ps_q.prescale_three_select};
    end

    always_comb begin
        div_d = div_q;
        if (unit_on) begin
            div_d = div_q + 15'h0001;
        end else begin
            div_d = `TCG_DIV_RST;
        end
    end

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_tick
            logic [15:0] mask;
            assign mask = (16'h0001 << sel_a[k]) - 16'h0001;
            // pulse once every two-to-the-field main clock cycles
            assign tick_d[k] = unit_on &&
                ((div_q & mask[`TCG_DIV_W-1:0]) ==
                mask[`TCG_DIV_W-1:0]);
        end
    endgenerate

    // ------------------------------------------------------------
    // channel clock pick
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < `TCG_CHANNELS; c++) begin : g_chan
            logic pick_tick;
            always_comb begin
                case (pick_q[c])
                    TCG_PICK_ZERO: pick_tick = tick_d[0];
                    TCG_PICK_TWO: pick_tick = tick_d[2];
                    TCG_PICK_ONE: pick_tick = tick_d[1];
                    TCG_PICK_THREE: pick_tick = tick_d[3];
                    default: pick_tick = 1'b0;
                endcase
            end
            assign chan_d[c] = pick_tick;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= `TCG_DIV_RST;
        end else begin
            div_q <= div_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick_q <= 4'h0;
        end else begin
            tick_q <= tick_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chan_q <= '0;
        end else begin
            chan_q <= chan_d;
        end
    end

    assign prescaled_clock = tick_q;
    assign channel_tick = chan_q;

endmodule

`default_nettype wire

// *** test/tcg_properties.sv ***
`default_nettype none
module tcg_properties
    import tcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] peripheral_clock_gate,
    input wire logic [3:0] prescaled_clock,
    input wire logic [7:0] channel_tick
);
// ----------
// checks
// ----------
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire acc = psel && penable;
a_gate_stops_ticks: assert property (!peripheral_clock_gate[0] [*2]
    |-> prescaled_clock == 4'h0 && channel_tick == 8'h00)
    else $error("tick while gated");
a_gate_write_lands: assert property (acc && pwrite && paddr == 12'h000
    |=> peripheral_clock_gate == $past(pwdata[7:0]))
    else $error("gate write lost");
a_gate_read_back: assert property (acc && !pwrite && paddr == 12'h000
    |-> prdata == {24'h000000, peripheral_clock_gate})
    else $error("gate read wrong");
a_select_mask_zero: assert property (acc && !pwrite && paddr == 12'h004
    |-> prdata[31:14] == 18'h00000 && prdata[11:10] == 2'h0 && !pslverr)
    else $error("select mask wrong");
a_unmapped_error: assert property (acc && paddr == 12'h00C
    |-> pslverr && (pwrite || prdata == 32'h00000000))
    else $error("unmapped not refused");
endmodule
bind tcg_top tcg_properties u_props (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .peripheral_clock_gate,
    .prescaled_clock, .channel_tick);
`default_nettype wire

// *** test/tcg_top_tb.sv ***
`default_nettype none
module tcg_top_tb import tcg_pkg::*;;
timeunit 1ns;
timeprecision 1ps;
logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rdat;
logic pready, pslverr, rerr;
logic [7:0] gate, tick;
logic [3:0] pclk;
wire [11:0] ev = {tick, pclk};
int failures = 0, checked = 0;
int pe[4] = '{32, 2, 8, 4};
tcg_top DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .peripheral_clock_gate(gate),
    .prescaled_clock(pclk), .channel_tick(tick));
initial forever #5 clk = ~clk;
// ----------
// tasks
// ----------
task conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
        failures++;
        $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
        @(posedge clk);
        if (pready === 1'b1) break;
    end
    if (i == 20) begin
        failures++;
        conclude();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(0, a, 0);
    cmp(n, e, rdat);
endtask
task period(input int k, input int e, input string n);
    int i, s, np;
    np = 0;
    for (i = 0; i < 300; i++) begin
        @(posedge clk);
        #1;
        if (ev[k] === 1'b1) begin
            np++;
            if (np == 3) break;
            s = i;
        end
    end
    if (i == 300) begin
        failures++;
        conclude();
    end
    cmp(n, e, i - s);
endtask
// ----------
// sequence
// ----------
initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(12'h000, 32'h0, "gate rst");
    apb(1, 12'h004, 32'h2135);
    rd(12'h004, 32'h0, "gated sel");
    apb(1, 12'h000, 32'h1A5);
    rd(12'h000, 32'hA5, "gate");
    cmp("gate pin", 32'hA5, {24'h000000, gate});
    apb(1, 12'h000, 32'h01);
    apb(1, 12'h004, 32'hFFFF);
    rd(12'h004, 32'h33FF, "sel mask");
    for (int s = 0; s < 6; s++) begin
        apb(1, 12'h004, 32'h2130 | s);
        period(0, 1 << s, "clock0");
    end
    period(1, 8, "clock1");
    period(2, 2, "clock2");
    period(3, 4, "clock3");
    for (int p = 0; p < 4; p++) begin
        apb(1, 12'h010, p << 14);
        rd(12'h010, p << 14, "pick");
        period(4, pe[p], "tick0");
    end
    apb(1, 12'h02C, 32'hFFFF);
    rd(12'h02C, 32'hC000, "pick7");
    period(11, 4, "tick7");
    rd(12'h010, 32'hC000, "pick0 kept");
    rd(12'h00C, 32'h0, "unmapped");
    cmp("slverr", 32'h1, {31'h0, rerr});
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h004, 32'h0);
    rd(12'h004, 32'h2135, "held");
    rd(12'h008, 32'h0, "div idle");
    repeat (5) @(posedge clk);
    #1;
    cmp("stopped", 32'h0, {20'h00000, ev});
    conclude();
end
endmodule
`default_nettype wire
